// File: logic/tmr_pkg.sv
// Constants, register map and carriers for the 8-bit compare/PWM timer.
// Assumes an APB slave with 32-bit data, one aligned word per register.
package tmr_pkg;
    // Register byte addresses
    localparam logic [11:0] TMR_CTRL_ADDR   = 12'h000;
    localparam logic [11:0] TMR_COUNT_ADDR  = 12'h004;
    localparam logic [11:0] TMR_CMP_ADDR    = 12'h008;
    localparam logic [11:0] TMR_STATUS_ADDR = 12'h00c;
    localparam logic [11:0] TMR_CFG_ADDR    = 12'h010;
    // Control register fields
    localparam int TMR_FORCE_BIT = 7;
    localparam int TMR_WGM0_BIT  = 6;
    localparam int TMR_COM_HI    = 5;
    localparam int TMR_COM_LO    = 4;
    localparam int TMR_WGM1_BIT  = 3;
    localparam int TMR_CS_HI     = 2;
    // Status and config bits
    localparam int TMR_OVF_BIT   = 0;
    localparam int TMR_CMPF_BIT  = 1;
    localparam int TMR_ASYNC_BIT = 0;
    localparam int TMR_DDR_BIT   = 1;
    localparam logic [7:0] TMR_CTRL_RST = 8'h00;
    localparam logic [7:0] TMR_BOTTOM   = 8'h00;
    localparam logic [7:0] TMR_MAX      = 8'hff;
    localparam int TMR_PRE_W = 10;

    typedef enum logic [1:0] {
        TMR_NORMAL, TMR_PHASE_PWM, TMR_CLEAR_ON_MATCH, TMR_FAST_PWM
    } tmr_mode_t;

    // Compare output actions
    typedef enum logic [1:0] {
        TMR_ACT_NONE, TMR_ACT_TOGGLE, TMR_ACT_CLEAR, TMR_ACT_SET
    } tmr_act_t;

    typedef struct packed {
        logic       forceCmp;
        tmr_mode_t  mode;
        logic [1:0] compareOutputSel;
        logic [2:0] tickSourceSel;
    } tmr_ctrl_t;
endpackage

// File: logic/tmr_prescaler.sv
// Prescaler: free-running divider producing the selected timer tick.
// Assumes a single clock; the tick is a one-cycle enable pulse.
`timescale 1ns/10ps
module tmr_prescaler
    import tmr_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [2:0] tickSourceSel,
    output logic            tick
);
    logic [TMR_PRE_W-1:0] preCount;

    // Free-running count; taps give power-of-two divides
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            preCount <= '0;
        end else begin
            preCount <= preCount + 1'b1;
        end
    end

    // Tap select: all lower bits ones means divide boundary
    always_comb begin
        case (tickSourceSel)
            3'h0: tick = 1'b0;
            3'h1: tick = 1'b1;
            3'h2: tick = &preCount[2:0];
            3'h3: tick = &preCount[4:0];
            3'h4: tick = &preCount[5:0];
            3'h5: tick = &preCount[6:0];
            3'h6: tick = &preCount[7:0];
            default: tick = &preCount[9:0];
        endcase
    end
endmodule

// File: logic/tmr_timer.sv
// 8-bit timer/counter with one compare channel and PWM output, APB slave.
// Assumes pclk is the I/O clock; the asynchronous oscillator is external.
//
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/10ps
module tmr_timer
    import tmr_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        portOut,
    output logic             comparePinOut,
    output logic             comparePinOe,
    output logic             asyncSelect
);
    tmr_ctrl_t   ctrl;
    logic [7:0]  counterValue;
    logic [7:0]  compareValue;
    logic [7:0]  compareBuffer;
    logic        countDown;
    logic        blockMatch;
    logic        compareOut;
    logic        overflowFlag;
    logic        compareMatchFlag;
    logic        portDir;
    logic        tick;
    logic        wrStrobe;
    logic        rdStrobe;
    logic        forceNow;
    logic        isPwm;
    logic        match;
    logic        matchEff;
    logic [7:0]  topValue;
    logic        atTop;
    logic        ovfEvent;
    logic        cmpEvent;
    logic        clearOnMatch;
    logic [7:0]  next_counter;
    logic        next_countDown;
    logic        next_out;

    // Address decode for one register
    function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
        hit = (a == r);
    endfunction

    // Zero-wait APB: every access completes in its access phase
    assign pready   = 1'b1;
    assign wrStrobe = psel && penable && pwrite && pstrb[0];
    assign rdStrobe = psel && penable && !pwrite;
    assign pslverr  = psel && penable && !(hit(paddr, TMR_CTRL_ADDR)
                      || hit(paddr, TMR_COUNT_ADDR) || hit(paddr, TMR_CMP_ADDR)
                      || hit(paddr, TMR_STATUS_ADDR) || hit(paddr, TMR_CFG_ADDR));

    assign isPwm    = (ctrl.mode == TMR_PHASE_PWM) || (ctrl.mode == TMR_FAST_PWM);
    // Force only honoured outside PWM; software must write zero there
    // Modes 1 and 3 both carry the low mode bit, so a write entering PWM drops it too
    assign forceNow = wrStrobe && hit(paddr, TMR_CTRL_ADDR)
                      && pwdata[TMR_FORCE_BIT] && !isPwm
                      && !pwdata[TMR_WGM0_BIT];
    assign topValue = (ctrl.mode == TMR_CLEAR_ON_MATCH) ? compareValue : TMR_MAX;
    assign atTop    = (counterValue == topValue);
    assign match    = (counterValue == compareValue);
    // In PWM a compare equal to TOP gives no match; TOP action does it
    assign matchEff = match && !blockMatch
                      && !(isPwm && compareValue == TMR_MAX && ctrl.compareOutputSel[1]);
    assign clearOnMatch = (ctrl.mode == TMR_CLEAR_ON_MATCH) && match && !blockMatch;
    assign ovfEvent = tick && ((ctrl.mode == TMR_PHASE_PWM)
                      ? (counterValue == TMR_BOTTOM && countDown)
                      : (counterValue == TMR_MAX));
    assign cmpEvent = tick && match && !blockMatch;

    // Control register; force bit is a strobe and never stored
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= tmr_ctrl_t'(TMR_CTRL_RST);
        end else if (wrStrobe && hit(paddr, TMR_CTRL_ADDR)) begin
            ctrl.forceCmp         <= 1'b0;
            ctrl.mode             <= tmr_mode_t'({pwdata[TMR_WGM1_BIT], pwdata[TMR_WGM0_BIT]});
            ctrl.compareOutputSel <= pwdata[TMR_COM_HI:TMR_COM_LO];
            ctrl.tickSourceSel    <= pwdata[TMR_CS_HI:0];
        end
    end

    // Config: async source select and pin direction
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            asyncSelect <= 1'b0;
            portDir     <= 1'b0;
        end else if (wrStrobe && hit(paddr, TMR_CFG_ADDR)) begin
            asyncSelect <= pwdata[TMR_ASYNC_BIT];
            portDir     <= pwdata[TMR_DDR_BIT];
        end
    end

    tmr_prescaler u_pre (
        .clk           (clk),
        .rst_n         (rst_n),
        .tickSourceSel (ctrl.tickSourceSel),
        .tick          (tick)
    );

    // Next count per waveform mode
    always_comb begin
        next_counter   = counterValue;
        next_countDown = countDown;
        case (ctrl.mode)
            TMR_PHASE_PWM: begin
                // MAX held one tick while direction turns
                if (!countDown && counterValue == TMR_MAX) begin
                    next_countDown = 1'b1;
                end else if (countDown && counterValue == TMR_BOTTOM) begin
                    next_countDown = 1'b0;
                    next_counter   = counterValue + 8'h01;
                end else if (countDown) begin
                    next_counter = counterValue - 8'h01;
                end else begin
                    next_counter = counterValue + 8'h01;
                end
            end
            TMR_CLEAR_ON_MATCH: begin
                next_countDown = 1'b0;
                next_counter   = clearOnMatch ? TMR_BOTTOM : counterValue + 8'h01;
            end
            default: begin
                // Wraps MAX to BOTTOM on the following tick
                next_countDown = 1'b0;
                next_counter   = counterValue + 8'h01;
            end
        endcase
    end

    // Counter runs on clk, advancing only on tick
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            counterValue <= TMR_BOTTOM;
            countDown    <= 1'b0;
        end else if (wrStrobe && hit(paddr, TMR_COUNT_ADDR)) begin
            counterValue <= pwdata[7:0];
        end else if (tick) begin
            counterValue <= next_counter;
            countDown    <= next_countDown;
        end
    end

    // Write to counter blocks the match on the next tick
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            blockMatch <= 1'b0;
        end else if (wrStrobe && hit(paddr, TMR_COUNT_ADDR)) begin
            blockMatch <= 1'b1;
        end else if (tick) begin
            blockMatch <= 1'b0;
        end
    end

    // Compare buffer: immediate outside PWM, loaded at TOP in PWM
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            compareBuffer <= TMR_BOTTOM;
        end else if (wrStrobe && hit(paddr, TMR_CMP_ADDR)) begin
            compareBuffer <= pwdata[7:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            compareValue <= TMR_BOTTOM;
        end else if (!isPwm) begin
            compareValue <= compareBuffer;
        end else if (tick && counterValue == TMR_MAX && !countDown) begin
            compareValue <= compareBuffer;
        end
    end

    // Apply one compare-output action
    function automatic logic applyAct(input logic cur, input tmr_act_t a);
        case (a)
            TMR_ACT_TOGGLE: applyAct = !cur;
            TMR_ACT_CLEAR:  applyAct = 1'b0;
            TMR_ACT_SET:    applyAct = 1'b1;
            default:        applyAct = cur;
        endcase
    endfunction

    // Waveform output next value by mode and output select
    always_comb begin
        next_out = compareOut;
        case (ctrl.mode)
            TMR_FAST_PWM: begin
                if (ctrl.compareOutputSel[1] && tick) begin
                    if (atTop) begin
                        next_out = !ctrl.compareOutputSel[0];
                    end else if (matchEff) begin
                        next_out = ctrl.compareOutputSel[0];
                    end
                end
            end
            TMR_PHASE_PWM: begin
                if (ctrl.compareOutputSel[1] && tick) begin
                    // Compare at MAX: hold the down-count level so the output stays flat
                    if (counterValue == TMR_MAX && compareValue == TMR_MAX) begin
                        next_out = !ctrl.compareOutputSel[0];
                    end else if (matchEff) begin
                        next_out = countDown ? !ctrl.compareOutputSel[0]
                                             : ctrl.compareOutputSel[0];
                    end
                end
            end
            default: begin
                if (forceNow) begin
                    next_out = applyAct(compareOut, tmr_act_t'(pwdata[TMR_COM_HI:TMR_COM_LO]));
                end else if (tick && matchEff) begin
                    next_out = applyAct(compareOut, tmr_act_t'(ctrl.compareOutputSel));
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            compareOut <= 1'b0;
        end else begin
            compareOut <= next_out;
        end
    end

    // Pin mux: compare output overrides port when select nonzero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            comparePinOut <= 1'b0;
            comparePinOe  <= 1'b0;
        end else begin
            comparePinOut <= (|ctrl.compareOutputSel) ? next_out : portOut;
            comparePinOe  <= portDir;
        end
    end

    // Sticky flags; write one clears, a new event wins over the clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            overflowFlag     <= 1'b0;
            compareMatchFlag <= 1'b0;
        end else begin
            if (ovfEvent) begin
                overflowFlag <= 1'b1;
            end else if (wrStrobe && hit(paddr, TMR_STATUS_ADDR) && pwdata[TMR_OVF_BIT]) begin
                overflowFlag <= 1'b0;
            end
            // Forced compares never reach this path
            if (cmpEvent) begin
                compareMatchFlag <= 1'b1;
            end else if (wrStrobe && hit(paddr, TMR_STATUS_ADDR) && pwdata[TMR_CMPF_BIT]) begin
                compareMatchFlag <= 1'b0;
            end
        end
    end

    // Read mux, combinational so data stands in the access cycle
    always_comb begin
        prdata = 32'h0000_0000;
        if (rdStrobe) begin
            if (hit(paddr, TMR_CTRL_ADDR)) begin
                prdata[7:0] = {1'b0, ctrl.mode[0], ctrl.compareOutputSel,
                               ctrl.mode[1], ctrl.tickSourceSel};
            end else if (hit(paddr, TMR_COUNT_ADDR)) begin
                prdata[7:0] = counterValue;
            end else if (hit(paddr, TMR_CMP_ADDR)) begin
                prdata[7:0] = compareBuffer;
            end else if (hit(paddr, TMR_STATUS_ADDR)) begin
                prdata[1:0] = {compareMatchFlag, overflowFlag};
            end else if (hit(paddr, TMR_CFG_ADDR)) begin
                prdata[1:0] = {portDir, asyncSelect};
            end
        end
    end

    // Checks
    flag_after_tick_a: assert property (@(posedge clk) disable iff (!rst_n)
        cmpEvent |=> compareMatchFlag) else $error("match flag not set");
    force_no_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
        (forceNow && !cmpEvent && !compareMatchFlag) |=> !compareMatchFlag)
        else $error("force set flag");
    force_pwm_ignored_a: assert property (@(posedge clk) disable iff (!rst_n)
        (wrStrobe && hit(paddr, TMR_CTRL_ADDR) && pwdata[TMR_FORCE_BIT]
        && (isPwm || pwdata[TMR_WGM0_BIT]) && !tick) |=> $stable(compareOut))
        else $error("force in pwm");
    ctrl_force_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
        rdStrobe && hit(paddr, TMR_CTRL_ADDR) |-> !prdata[TMR_FORCE_BIT])
        else $error("force reads one");
    ctc_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        (tick && clearOnMatch && !wrStrobe) |=> counterValue == TMR_BOTTOM)
        else $error("ctc not cleared");
    stop_holds_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ctrl.tickSourceSel == 3'h0 && !wrStrobe) |=> $stable(counterValue))
        else $error("stopped counter moved");
    fast_wrap_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ctrl.mode == TMR_FAST_PWM && tick && counterValue == TMR_MAX && !wrStrobe)
        |=> counterValue == TMR_BOTTOM) else $error("fast pwm no wrap");
    block_match_a: assert property (@(posedge clk) disable iff (!rst_n)
        (wrStrobe && hit(paddr, TMR_COUNT_ADDR)) |=> !cmpEvent)
        else $error("match not blocked");
    cover_ovf_c: cover property (@(posedge clk) ovfEvent);
    cover_force_c: cover property (@(posedge clk) forceNow);
    cover_phase_c: cover property (@(posedge clk) ctrl.mode == TMR_PHASE_PWM && countDown);
    cover_ctc_c: cover property (@(posedge clk) tick && clearOnMatch);
    cover_fast_c: cover property (@(posedge clk) ctrl.mode == TMR_FAST_PWM && tick && atTop);

    // Sequencing, buffering and pin checks
    phase_max_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ctrl.mode == TMR_PHASE_PWM && tick && counterValue == TMR_MAX && !countDown
        && !wrStrobe) |=> counterValue == TMR_MAX) else $error("max not held");
    phase_ovf_bottom_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ctrl.mode == TMR_PHASE_PWM && counterValue == TMR_MAX) |-> !ovfEvent)
        else $error("phase overflow at max");
    ovf_at_max_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ctrl.mode != TMR_PHASE_PWM && tick && counterValue == TMR_MAX) |=> overflowFlag)
        else $error("overflow flag missing");
    cmp_hold_pwm_a: assert property (@(posedge clk) disable iff (!rst_n)
        (isPwm && !(tick && counterValue == TMR_MAX && !countDown)) |=> $stable(compareValue))
        else $error("compare updated off top");
    fast_set_top_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ctrl.mode == TMR_FAST_PWM && ctrl.compareOutputSel == 2'b10 && tick && atTop)
        |=> compareOut) else $error("fast pwm not set at top");
    phase_top_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ctrl.mode == TMR_PHASE_PWM && ctrl.compareOutputSel[1] && tick
        && counterValue == TMR_MAX && compareValue == TMR_MAX)
        |=> compareOut != $past(ctrl.compareOutputSel[0])) else $error("top action wrong");
    pin_oe_dir_a: assert property (@(posedge clk) disable iff (!rst_n)
        portDir |=> comparePinOe) else $error("pin driver off");
    pin_port_mux_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ctrl.compareOutputSel == 2'b00) |=> comparePinOut == $past(portOut))
        else $error("port data not passed");
endmodule

// File: dv/tmr_timer_tb.sv
// Self-checking bench for the 8-bit compare/PWM timer, driven over APB.
// Assumes zero-wait APB slave and a free-running prescaler inside the block.
`timescale 1ns/10ps
module tmr_timer_tb
    import tmr_pkg::*;
;
    logic        clk;
    logic        rst_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        portOut;
    logic        comparePinOut;
    logic        comparePinOe;
    logic        asyncSelect;
    logic        probe;
    logic [7:0]  lfsr;
    logic [32:0] rdQ[$];
    logic [2:0]  pinQ[$];
    int          errors;
    int          num_checks;
    int          divs[6] = '{8, 32, 64, 128, 256, 1024};

    tmr_timer dut_u (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .portOut(portOut), .comparePinOut(comparePinOut),
        .comparePinOe(comparePinOe), .asyncSelect(asyncSelect)
    );

    // Free-running 100 MHz clock
    always #5 clk = ~clk;

    function automatic logic [7:0] nxt(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction

    // Control word: force, mode low, output select, mode high, tick select
    function automatic logic [31:0] ctl(input logic [1:0] m, input logic [1:0] c,
                                        input logic [2:0] s, input logic f);
        return {24'h0, f, m[0], c, m[1], s};
    endfunction

    task automatic cmp(input logic [32:0] exp, input logic [32:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; request held until pready is seen high
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                        input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge clk);
        end
        if (n >= 20) errors++;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 4'h1);
    endtask

    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        rdQ.push_back(e);
        xfer(1'b0, a, 32'h0, 4'h0);
    endtask

    // Pin vector is {asyncSelect, comparePinOe, comparePinOut}
    task automatic pin(input logic [2:0] e);
        pinQ.push_back(e);
        @(posedge clk);
        probe <= 1'b1;
        @(posedge clk);
        probe <= 1'b0;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Start ticking from 0xfe with the given select, stop after n idle cycles
    task automatic run_pre(input logic [2:0] s, input int n);
        wr(TMR_STATUS_ADDR, 32'h3);
        wr(TMR_COUNT_ADDR, 32'hfe);
        wr(TMR_CTRL_ADDR, ctl(2'd0, 2'd0, s, 1'b0));
        idle(n);
        wr(TMR_CTRL_ADDR, ctl(2'd0, 2'd0, 3'd0, 1'b0));
    endtask

    // Monitor at the falling edge, where read data and pins are settled
    always @(negedge clk) begin
        if (psel === 1'b1 && penable === 1'b1 && pwrite === 1'b0 && pready === 1'b1) begin
            if (rdQ.size() > 0) cmp(rdQ.pop_front(), {pslverr, prdata});
            else cmp(33'h0, 33'h1ffffffff);
        end
        if (probe === 1'b1 && pinQ.size() > 0) begin
            cmp({30'h0, pinQ.pop_front()}, {30'h0, asyncSelect, comparePinOe, comparePinOut});
        end
    end

    task automatic final_report();
        if (rdQ.size() != 0 || pinQ.size() != 0) errors++;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Watchdog well beyond the expected run of roughly 5k cycles
    initial begin
        #600000;
        errors++;
        $display("watchdog expired at %0t", $time);
        final_report();
    end

    initial begin
        logic [7:0] v;
        logic [1:0] coms[4] = '{2'd3, 2'd2, 2'd1, 2'd1};
        logic       pins[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
        clk = 1'b0; rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h0; pwdata = 32'h0; pstrb = 4'h0; probe = 1'b0;
        lfsr = 8'h45; portOut = 1'b0; errors = 0; num_checks = 0;
        repeat (3) @(posedge clk);
        rst_n   <= 1'b1;
        portOut <= lfsr[0];
        // Reset state and register access
        rd(TMR_CTRL_ADDR, {1'b0, 24'h0, TMR_CTRL_RST});
        rd(TMR_STATUS_ADDR, 33'h0);
        pin({2'b00, lfsr[0]});
        for (int i = 0; i < 4; i++) begin
            lfsr = nxt(lfsr);
            wr(TMR_COUNT_ADDR, {24'h0, lfsr});
            rd(TMR_COUNT_ADDR, {25'h0, lfsr});
            v = nxt(lfsr);
            wr(TMR_CMP_ADDR, {24'h0, v});
            rd(TMR_CMP_ADDR, {25'h0, v});
            xfer(1'b1, TMR_CMP_ADDR, {24'h0, ~v}, 4'h0);
            rd(TMR_CMP_ADDR, {25'h0, v});
        end
        rd(12'h014, {1'b1, 32'h0});
        wr(TMR_CFG_ADDR, 32'h3);
        pin({2'b11, lfsr[0] ^ lfsr[0] ^ portOut});
        wr(TMR_CFG_ADDR, 32'h2);
        $display("test registers done");
        // Forced compare in normal mode for set, clear and toggle, then set in clear-on-match mode
        for (int i = 0; i < 4; i++) begin
            wr(TMR_CTRL_ADDR, ctl(2'd0, coms[i], 3'd0, 1'b1));
            rd(TMR_CTRL_ADDR, {1'b0, ctl(2'd0, coms[i], 3'd0, 1'b0)});
            idle(2);
            pin({2'b01, pins[i]});
        end
        wr(TMR_COUNT_ADDR, 32'h33);
        wr(TMR_CMP_ADDR, 32'h33);
        wr(TMR_CTRL_ADDR, ctl(2'd2, 2'd3, 3'd0, 1'b1));
        idle(2);
        rd(TMR_COUNT_ADDR, 33'h33);
        rd(TMR_STATUS_ADDR, 33'h0);
        // Forced clear in normal mode, then force written entering phase PWM on purpose: must be ignored
        wr(TMR_CTRL_ADDR, ctl(2'd0, 2'd2, 3'd0, 1'b1));
        wr(TMR_CTRL_ADDR, ctl(2'd1, 2'd3, 3'd0, 1'b1));
        idle(2);
        pin(3'b010);
        $display("test force done");
        // Clear-on-match keeps the counter below MAX
        wr(TMR_CTRL_ADDR, ctl(2'd2, 2'd1, 3'd0, 1'b0));
        wr(TMR_CMP_ADDR, 32'h5);
        wr(TMR_COUNT_ADDR, 32'h0);
        wr(TMR_STATUS_ADDR, 32'h3);
        wr(TMR_CTRL_ADDR, ctl(2'd2, 2'd1, 3'd1, 1'b0));
        idle(40);
        wr(TMR_CTRL_ADDR, ctl(2'd2, 2'd1, 3'd0, 1'b0));
        rd(TMR_STATUS_ADDR, 33'h2);
        $display("test clear on match done");
        // Counter write suppresses the match on the next tick only
        for (int k = 0; k < 2; k++) begin
            wr(TMR_CTRL_ADDR, ctl(2'd0, 2'd0, 3'd0, 1'b0));
            wr(TMR_CMP_ADDR, 32'h20);
            wr(TMR_STATUS_ADDR, 32'h3);
            wr(TMR_COUNT_ADDR, 32'h20 - k);
            wr(TMR_CTRL_ADDR, ctl(2'd0, 2'd0, 3'd1, 1'b0));
            idle(20);
            wr(TMR_CTRL_ADDR, ctl(2'd0, 2'd0, 3'd0, 1'b0));
            rd(TMR_STATUS_ADDR, (k == 1) ? 33'h2 : 33'h0);
        end
        $display("test counter write done");
        // Tick select: stopped, undivided and every divider
        wr(TMR_CMP_ADDR, 32'h80);
        run_pre(3'd0, 100);
        rd(TMR_COUNT_ADDR, 33'hfe);
        rd(TMR_STATUS_ADDR, 33'h0);
        run_pre(3'd1, 3);
        rd(TMR_STATUS_ADDR, 33'h1);
        for (int s = 2; s < 8; s++) begin
            run_pre(s[2:0], divs[s-2] - 6);
            rd(TMR_STATUS_ADDR, 33'h0);
            run_pre(s[2:0], 2 * divs[s-2] + 4);
            rd(TMR_STATUS_ADDR, 33'h1);
        end
        $display("test prescaler done");
        // Fast PWM, inverting: set on match, clear when wrapping at TOP
        wr(TMR_CTRL_ADDR, ctl(2'd0, 2'd2, 3'd0, 1'b1));
        wr(TMR_CMP_ADDR, 32'h10);
        wr(TMR_STATUS_ADDR, 32'h3);
        wr(TMR_COUNT_ADDR, 32'h0e);
        wr(TMR_CTRL_ADDR, ctl(2'd3, 2'd3, 3'd1, 1'b0));
        idle(3);
        wr(TMR_CTRL_ADDR, ctl(2'd3, 2'd3, 3'd0, 1'b0));
        pin(3'b011);
        wr(TMR_COUNT_ADDR, 32'hfc);
        wr(TMR_CTRL_ADDR, ctl(2'd3, 2'd3, 3'd1, 1'b0));
        idle(6);
        wr(TMR_CTRL_ADDR, ctl(2'd3, 2'd3, 3'd0, 1'b0));
        pin(3'b010);
        rd(TMR_STATUS_ADDR, 33'h3);
        $display("test fast pwm done");
        // Phase PWM, non-inverting: clear going up, set coming down
        wr(TMR_CTRL_ADDR, ctl(2'd0, 2'd3, 3'd0, 1'b1));
        wr(TMR_CMP_ADDR, 32'hf8);
        idle(2);
        wr(TMR_STATUS_ADDR, 32'h3);
        wr(TMR_COUNT_ADDR, 32'hf6);
        wr(TMR_CTRL_ADDR, ctl(2'd1, 2'd2, 3'd1, 1'b0));
        idle(3);
        wr(TMR_CTRL_ADDR, ctl(2'd1, 2'd2, 3'd0, 1'b0));
        pin(3'b010);
        wr(TMR_CTRL_ADDR, ctl(2'd1, 2'd2, 3'd1, 1'b0));
        idle(16);
        wr(TMR_CTRL_ADDR, ctl(2'd1, 2'd2, 3'd0, 1'b0));
        pin(3'b011);
        rd(TMR_STATUS_ADDR, 33'h2);
        $display("test phase pwm done");
        idle(4);
        final_report();
    end
endmodule
